// >>> src/mcv_pkg.sv
package mcv_pkg;

  localparam int unsigned MAX_LEN = 32;
  localparam int unsigned LEN_W = 6;
  localparam int unsigned CLK_HZ = 20_000_000;

  // Byte positions inside a message
  localparam logic [4:0] POS_CODE = 5'h00;
  localparam logic [4:0] POS_TAG_HI = 5'h02;
  localparam logic [4:0] POS_TAG_LO = 5'h03;
  localparam logic [4:0] POS_ALERT_TYPE = 5'h10;
  localparam logic [4:0] POS_RET_PATH = 5'h04;
  localparam logic [5:0] HDR_LEN = 6'h04;
  localparam logic [5:0] MIN_LEN_MASTER_ALERT = 6'h13;
  localparam logic [5:0] MIN_LEN_CFG_QUIESCE = 6'h08;

  // Code map bounds
  localparam logic [7:0] CODE_PRIV_LAST = 8'h11;
  localparam logic [7:0] CODE_PRIV_RSV_LAST = 8'h1f;
  localparam logic [7:0] CODE_APP_FIRST = 8'h20;
  localparam logic [7:0] CODE_APP_LAST = 8'h23;
  localparam logic [7:0] CODE_ULP_FIRST = 8'h80;

  localparam logic [7:0] CODE_QUERY_NODE = 8'h00;
  localparam logic [7:0] CODE_CONFIGURE_PORT = 8'h02;
  localparam logic [7:0] CODE_MASTER_ALERT = 8'h05;
  localparam logic [7:0] CODE_QUIESCE = 8'h06;
  localparam logic [7:0] CODE_QUERY_PROTOCOL = 8'h08;
  localparam logic [7:0] CODE_QUERY_PORT = 8'h0a;

  // Alert codes: type, subtype, type information
  localparam logic [23:0] ALERT_UNKNOWN_MSG = 24'h020100;
  localparam logic [23:0] ALERT_TOO_SHORT = 24'h020200;
  localparam logic [23:0] ALERT_UNSUPPORTED_ULP = 24'h020300;

  // Master-generated alert subtypes, then alert types (type information byte assumed zero)
  localparam logic [7:0] MGA_ALL_NORMAL = 8'h01;
  localparam logic [7:0] MGA_NODE_NORMAL = 8'h02;
  localparam logic [7:0] MGA_RECONFIG = 8'h03;
  localparam logic [7:0] MGA_LINK_NORMAL = 8'h04;
  localparam logic [7:0] ATYPE_LINK_ERROR = 8'h05;
  localparam logic [7:0] ATYPE_MASTER_GEN = 8'h06;

  // Path byte: bit 7 is the continuation flag
  localparam int unsigned PATH_EXT_BIT = 7;
  localparam int unsigned PATH_BYTES = 4;

  typedef enum logic [1:0] {
    MCV_ROLE_NODE,
    MCV_ROLE_CFG_MGR,
    MCV_ROLE_MASTER
  } mcv_role_t;

  typedef enum logic [2:0] {
    MCV_OUT_NONE,
    MCV_OUT_ULP,
    MCV_OUT_ALERT,
    MCV_OUT_OVERLAP,
    MCV_OUT_DISCARD,
    MCV_OUT_PROCESS
  } mcv_outcome_t;

  typedef enum logic [1:0] {
    MCV_SEND_ANY,
    MCV_SEND_CFG,
    MCV_SEND_MASTER
  } mcv_sender_t;

  typedef enum logic [1:0] {
    MCV_RECV_ANY,
    MCV_RECV_CFG,
    MCV_RECV_MASTER,
    MCV_RECV_NONE
  } mcv_recv_t;

  // Minimum defined length per privileged/application code
  function automatic logic [5:0] min_len(input logic [7:0] code);
    min_len = HDR_LEN;
    if (code == CODE_MASTER_ALERT)
    begin
      min_len = MIN_LEN_MASTER_ALERT;
    end
    else if (code == CODE_CONFIGURE_PORT || code == CODE_QUIESCE)
    begin
      min_len = MIN_LEN_CFG_QUIESCE;
    end
  endfunction

endpackage

// >>> src/mcv_code_map.sv
`timescale 1ns/10ps
module mcv_code_map (
  input wire logic [7:0] code,
  input wire logic frame_priv,
  input wire mcv_pkg::mcv_role_t role,
  output logic defined,
  output logic usable
);

  mcv_pkg::mcv_sender_t snd;
  mcv_pkg::mcv_recv_t rcv;
  logic priv_code;
  logic app_code;
  logic recv_ok;

  always_comb
  begin
    priv_code = code <= mcv_pkg::CODE_PRIV_LAST;
    app_code = code >= mcv_pkg::CODE_APP_FIRST && code <= mcv_pkg::CODE_APP_LAST;
    snd = mcv_pkg::MCV_SEND_ANY;
    rcv = mcv_pkg::MCV_RECV_ANY;
    case (code)
      8'h00, 8'h06, 8'h08, 8'h0a, 8'h0c:
      begin
        snd = mcv_pkg::MCV_SEND_CFG;
      end
      8'h01, 8'h03, 8'h09, 8'h0b:
      begin
        rcv = mcv_pkg::MCV_RECV_CFG;
      end
      8'h02, 8'h07, 8'h10, 8'h11:
      begin
        snd = mcv_pkg::MCV_SEND_MASTER;
      end
      8'h04:
      begin
        rcv = mcv_pkg::MCV_RECV_MASTER;
      end
      8'h05, 8'h0f:
      begin
        snd = mcv_pkg::MCV_SEND_MASTER;
        rcv = mcv_pkg::MCV_RECV_CFG;
      end
      8'h0e:
      begin
        snd = mcv_pkg::MCV_SEND_CFG;
        rcv = mcv_pkg::MCV_RECV_MASTER;
      end
      default:
      begin
        rcv = mcv_pkg::MCV_RECV_ANY;
      end
    endcase
    // Sender type is not visible here; only the receiver role is checked
    recv_ok = (rcv == mcv_pkg::MCV_RECV_ANY)
      || (rcv == mcv_pkg::MCV_RECV_CFG && role != mcv_pkg::MCV_ROLE_NODE)
      || (rcv == mcv_pkg::MCV_RECV_MASTER && role == mcv_pkg::MCV_ROLE_MASTER);
    defined = priv_code || app_code;
    usable = defined && (priv_code == frame_priv) && recv_ok;
  end

endmodule

// >>> src/mcv_path_len.sv
`timescale 1ns/10ps
module mcv_path_len (
  input wire logic [31:0] path_raw,
  output logic [31:0] path_clean
);

  logic live;

  // Bytes after the first one with continuation clear read as zero
  always_comb
  begin
    live = 1'b1;
    path_clean = '0;
    for (int i = 0; i < mcv_pkg::PATH_BYTES; i++)
    begin
      if (live)
      begin
        path_clean[31 - 8 * i -: 8] = path_raw[31 - 8 * i -: 8];
        live = path_raw[31 - 8 * i - (7 - mcv_pkg::PATH_EXT_BIT)];
      end
    end
  end

endmodule

// >>> src/mcv_validator.sv
`timescale 1ns/10ps
module mcv_validator (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic msg_last,
  input wire logic frame_priv,
  input wire mcv_pkg::mcv_role_t role,
  input wire logic [7:0] src_id,
  input wire logic ulp_supported,
  input wire logic store_free,
  input wire logic outstanding_clear,
  input wire logic [7:0] outstanding_src,
  input wire logic quiesce_all_done,
  input wire logic reconfig_done,
  input wire logic path_all_normal,
  output logic outcome_valid,
  output mcv_pkg::mcv_outcome_t outcome,
  output logic [23:0] alert_code,
  output logic [7:0] msg_code,
  output logic [15:0] msg_tag,
  output logic [31:0] msg_path,
  output logic [7:0] msg_src,
  output logic invalidate_links,
  output logic halt_outbound,
  output logic send_quiesce,
  output logic master_response,
  output logic requery_nodes,
  output logic reissue_cmds,
  output logic clear_table,
  output logic start_reconfig,
  output logic ulp_all_ready,
  output logic ulp_node_ready
);

  typedef enum logic [2:0] {
    MCV_ST_IDLE,
    MCV_ST_QUIESCE,
    MCV_ST_REQUERY,
    MCV_ST_RECONFIG,
    MCV_ST_PATHWAIT
  } mcv_rec_t;

  logic [7:0] msg_ff [mcv_pkg::MAX_LEN];
  logic [7:0] nxt_msg [mcv_pkg::MAX_LEN];
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic out_v_ff;
  logic nxt_out_v;
  mcv_pkg::mcv_outcome_t out_ff;
  mcv_pkg::mcv_outcome_t nxt_out;
  logic [23:0] alert_ff;
  logic [23:0] nxt_alert;
  logic [7:0] src_ff;
  logic [7:0] nxt_src;
  logic busy_ff;
  logic nxt_busy;
  logic [7:0] busy_src_ff;
  logic [7:0] nxt_busy_src;
  mcv_rec_t rec_ff;
  mcv_rec_t nxt_rec;
  logic [10:0] act_ff;
  logic [10:0] nxt_act;
  logic defined;
  logic usable;
  logic [7:0] code_c;
  logic [31:0] path_raw;
  logic [5:0] total;
  logic guarded;

  mcv_code_map u_map (
    .code(code_c),
    .frame_priv(frame_priv),
    .role(role),
    .defined(defined),
    .usable(usable)
  );

  mcv_path_len u_path (
    .path_raw(path_raw),
    .path_clean(msg_path)
  );

  assign code_c = msg_ff[mcv_pkg::POS_CODE];
  assign path_raw = {msg_ff[mcv_pkg::POS_RET_PATH], msg_ff[mcv_pkg::POS_RET_PATH + 5'h01],
    msg_ff[mcv_pkg::POS_RET_PATH + 5'h02], msg_ff[mcv_pkg::POS_RET_PATH + 5'h03]};
  assign guarded = code_c == mcv_pkg::CODE_CONFIGURE_PORT || code_c == mcv_pkg::CODE_MASTER_ALERT
    || code_c == mcv_pkg::CODE_QUERY_PORT || code_c == mcv_pkg::CODE_QUERY_PROTOCOL
    || code_c == mcv_pkg::CODE_QUIESCE;

  // Capture: bytes past 32 are dropped, code and tag are fixed positions
  always_comb
  begin
    nxt_msg = msg_ff;
    nxt_cnt = cnt_ff;
    nxt_src = src_ff;
    total = cnt_ff;
    if (byte_valid)
    begin
      if (cnt_ff < 6'(mcv_pkg::MAX_LEN))
      begin
        nxt_msg[cnt_ff[4:0]] = byte_data;
        nxt_cnt = cnt_ff + 6'h01;
        total = cnt_ff + 6'h01;
      end
      if (cnt_ff == '0)
      begin
        nxt_src = src_id;
      end
    end
    if (out_v_ff)
    begin
      nxt_cnt = '0;
      for (int i = 0; i < mcv_pkg::MAX_LEN; i++)
      begin
        nxt_msg[i] = '0;
      end
    end
  end

  // Decision is made one cycle after the last byte, when all bytes are stored
  logic last_ff;
  logic nxt_last;
  logic [5:0] len_ff;
  logic [5:0] nxt_len;

  always_comb
  begin
    nxt_last = byte_valid && msg_last;
    nxt_len = total;
    nxt_out_v = 1'b0;
    nxt_out = mcv_pkg::MCV_OUT_NONE;
    nxt_alert = '0;
    nxt_busy = busy_ff;
    nxt_busy_src = busy_src_ff;
    if (outstanding_clear && busy_ff && outstanding_src == busy_src_ff)
    begin
      nxt_busy = 1'b0;
    end
    if (last_ff)
    begin
      nxt_out_v = 1'b1;
      if (code_c >= mcv_pkg::CODE_ULP_FIRST)
      begin
        if (ulp_supported)
        begin
          nxt_out = mcv_pkg::MCV_OUT_ULP;
        end
        else
        begin
          nxt_out = mcv_pkg::MCV_OUT_ALERT;
          nxt_alert = mcv_pkg::ALERT_UNSUPPORTED_ULP;
        end
      end
      else if (!defined || !usable)
      begin
        nxt_out = mcv_pkg::MCV_OUT_ALERT;
        nxt_alert = mcv_pkg::ALERT_UNKNOWN_MSG;
      end
      else if (len_ff < mcv_pkg::min_len(code_c))
      begin
        nxt_out = mcv_pkg::MCV_OUT_ALERT;
        nxt_alert = mcv_pkg::ALERT_TOO_SHORT;
      end
      else if (guarded && busy_ff && busy_src_ff == src_ff)
      begin
        nxt_out = mcv_pkg::MCV_OUT_OVERLAP;
      end
      else if (code_c == mcv_pkg::CODE_QUERY_NODE && !store_free)
      begin
        nxt_out = mcv_pkg::MCV_OUT_DISCARD;
      end
      else
      begin
        nxt_out = mcv_pkg::MCV_OUT_PROCESS;
        if (guarded)
        begin
          nxt_busy = 1'b1;
          nxt_busy_src = src_ff;
        end
      end
    end
  end

  // Master-alert follow-up as a configuration manager
  logic accept_ma;
  logic [7:0] atype;
  logic [7:0] asub;

  always_comb
  begin
    atype = msg_ff[mcv_pkg::POS_ALERT_TYPE];
    asub = msg_ff[mcv_pkg::POS_ALERT_TYPE + 5'h01];
    accept_ma = out_v_ff && out_ff == mcv_pkg::MCV_OUT_PROCESS && code_c == mcv_pkg::CODE_MASTER_ALERT
      && role != mcv_pkg::MCV_ROLE_NODE;
    nxt_rec = rec_ff;
    nxt_act = '0;
    case (rec_ff)
      MCV_ST_IDLE:
      begin
        if (accept_ma && atype == mcv_pkg::ATYPE_LINK_ERROR)
        begin
          nxt_act[0] = 1'b1;
          nxt_act[1] = 1'b1;
          nxt_act[2] = 1'b1;
          nxt_rec = MCV_ST_QUIESCE;
        end
        else if (accept_ma && atype == mcv_pkg::ATYPE_MASTER_GEN && asub == mcv_pkg::MGA_RECONFIG)
        begin
          nxt_act[6] = 1'b1;
          nxt_act[7] = 1'b1;
          nxt_rec = MCV_ST_RECONFIG;
        end
        else if (accept_ma && atype == mcv_pkg::ATYPE_MASTER_GEN && asub == mcv_pkg::MGA_ALL_NORMAL)
        begin
          nxt_act[8] = 1'b1;
          nxt_act[3] = 1'b1;
        end
        else if (accept_ma && atype == mcv_pkg::ATYPE_MASTER_GEN
          && (asub == mcv_pkg::MGA_LINK_NORMAL || asub == mcv_pkg::MGA_NODE_NORMAL))
        begin
          nxt_rec = MCV_ST_PATHWAIT;
        end
        else if (accept_ma)
        begin
          nxt_act[3] = 1'b1;
        end
      end
      MCV_ST_QUIESCE:
      begin
        if (quiesce_all_done)
        begin
          nxt_act[3] = 1'b1;
          nxt_act[4] = 1'b1;
          nxt_act[5] = 1'b1;
          nxt_rec = MCV_ST_IDLE;
        end
      end
      MCV_ST_RECONFIG:
      begin
        if (reconfig_done)
        begin
          nxt_act[3] = 1'b1;
          nxt_rec = MCV_ST_IDLE;
        end
      end
      MCV_ST_PATHWAIT:
      begin
        if (path_all_normal)
        begin
          nxt_act[9] = 1'b1;
          nxt_act[3] = 1'b1;
          nxt_rec = MCV_ST_IDLE;
        end
      end
      default:
      begin
        nxt_rec = MCV_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < mcv_pkg::MAX_LEN; i++)
      begin
        msg_ff[i] <= '0;
      end
      cnt_ff <= '0;
      src_ff <= '0;
      last_ff <= 1'b0;
      len_ff <= '0;
      out_v_ff <= 1'b0;
      out_ff <= mcv_pkg::MCV_OUT_NONE;
      alert_ff <= '0;
      busy_ff <= 1'b0;
      busy_src_ff <= '0;
      rec_ff <= MCV_ST_IDLE;
      act_ff <= '0;
    end
    else
    begin
      msg_ff <= nxt_msg;
      cnt_ff <= nxt_cnt;
      src_ff <= nxt_src;
      last_ff <= nxt_last;
      len_ff <= nxt_len;
      out_v_ff <= nxt_out_v;
      out_ff <= nxt_out;
      alert_ff <= nxt_alert;
      busy_ff <= nxt_busy;
      busy_src_ff <= nxt_busy_src;
      rec_ff <= nxt_rec;
      act_ff <= nxt_act;
    end
  end

  assign outcome_valid = out_v_ff;
  assign outcome = out_ff;
  assign alert_code = alert_ff;
  assign msg_code = code_c;
  assign msg_tag = {msg_ff[mcv_pkg::POS_TAG_HI], msg_ff[mcv_pkg::POS_TAG_LO]};
  assign msg_src = src_ff;
  assign invalidate_links = act_ff[0];
  assign halt_outbound = act_ff[1];
  assign send_quiesce = act_ff[2];
  assign master_response = act_ff[3];
  assign requery_nodes = act_ff[4];
  assign reissue_cmds = act_ff[5];
  assign clear_table = act_ff[6];
  assign start_reconfig = act_ff[7];
  assign ulp_all_ready = act_ff[8];
  assign ulp_node_ready = act_ff[9];

endmodule

// >>> tb/mcv_sender.sv
`timescale 1ns/10ps
module mcv_sender (
  input wire logic clk,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic msg_last,
  output logic frame_priv,
  output logic [7:0] src_id
);
  logic busy = 1'b0;

  initial
  begin
    byte_valid = 1'b0;
    byte_data = 8'h5a;
    msg_last = 1'b0;
    frame_priv = 1'b1;
    src_id = 8'h00;
  end

  // Idle data keeps moving so a stale byte never looks valid
  always @(posedge clk)
    if (!busy)
      byte_data <= ~byte_data;

  task automatic send(input logic [255:0] m, input int n, input logic priv, input logic [7:0] src);
    busy = 1'b1;
    for (int i = 0; i < n && i < 32; i++)
    begin
      @(posedge clk);
      byte_valid <= 1'b1;
      byte_data <= m[8*i +: 8];
      msg_last <= (i == n - 1);
      frame_priv <= priv;
      src_id <= src;
    end
    @(posedge clk);
    byte_valid <= 1'b0;
    msg_last <= 1'b0;
    @(posedge clk);
    busy = 1'b0;
    @(posedge clk);
  endtask
endmodule

// >>> tb/mcv_validator_props.sv
`timescale 1ns/10ps
module mcv_validator_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic msg_last,
  input wire logic frame_priv,
  input wire logic ulp_supported,
  input wire logic outcome_valid,
  input wire mcv_pkg::mcv_outcome_t outcome,
  input wire logic [23:0] alert_code,
  input wire logic [7:0] msg_code,
  input wire logic invalidate_links,
  input wire logic halt_outbound,
  input wire logic send_quiesce,
  input wire logic master_response,
  input wire logic clear_table,
  input wire logic start_reconfig
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  answer_time_a: assert property (byte_valid && msg_last |-> ##2 outcome_valid)
    else $error("late outcome");
  ulp_pass_a: assert property (outcome_valid && msg_code >= 8'h80 && $past(ulp_supported)
    |-> outcome == mcv_pkg::MCV_OUT_ULP) else $error("upper message not passed");
  ulp_refuse_a: assert property (outcome_valid && msg_code >= 8'h80 && !$past(ulp_supported)
    |-> alert_code == mcv_pkg::ALERT_UNSUPPORTED_ULP) else $error("unsupported upper code not alerted");
  reserved_code_a: assert property (outcome_valid && msg_code inside {[8'h12:8'h1f], [8'h24:8'h7f]}
    |-> alert_code == mcv_pkg::ALERT_UNKNOWN_MSG) else $error("reserved code not alerted");
  frame_match_a: assert property (outcome_valid && msg_code < 8'h24
    && (msg_code < 8'h20) != $past(frame_priv, 2) |-> outcome == mcv_pkg::MCV_OUT_ALERT)
    else $error("frame mismatch not alerted");
  drop_silent_a: assert property (outcome_valid && outcome == mcv_pkg::MCV_OUT_DISCARD
    |-> msg_code == 8'h00 && alert_code == 24'h0) else $error("bad discard");
  link_error_a: assert property ($rose(invalidate_links) |-> halt_outbound && send_quiesce && !master_response)
    else $error("link error actions split");
  reconfig_pair_a: assert property (clear_table |-> start_reconfig ##1 !clear_table)
    else $error("reconfig actions split");
endmodule

bind mcv_validator mcv_validator_props chk_u (.clk, .reset_n, .byte_valid, .msg_last, .frame_priv, .ulp_supported,
  .outcome_valid, .outcome, .alert_code, .msg_code, .invalidate_links, .halt_outbound, .send_quiesce, .master_response,
  .clear_table,
  .start_reconfig);

// >>> tb/mcv_validator_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value at %0t: %h not %h", $time, a, e); end end
module mcv_validator_tb;
  logic clk, reset_n, byte_valid, msg_last, frame_priv, ulp_supported, store_free, outstanding_clear;
  logic quiesce_all_done, reconfig_done, path_all_normal, outcome_valid;
  logic invalidate_links, master_response, clear_table, ulp_all_ready, ulp_node_ready, requery_nodes, reissue_cmds;
  logic [7:0] byte_data, src_id, outstanding_src, msg_code, msg_src, cur_src;
  logic [23:0] alert_code;
  logic [15:0] msg_tag;
  logic [31:0] msg_path;
  logic [31:0] lfsr = 32'h0145abb6;
  logic [90:0] got;
  logic [90:0] exp_q[$];
  logic [8:0] bad [6] = '{9'h112, 9'h11f, 9'h024, 9'h07f, 9'h120, 9'h011};
  mcv_pkg::mcv_role_t role;
  mcv_pkg::mcv_outcome_t outcome;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;

  mcv_sender snd_u (.clk, .byte_valid, .byte_data, .msg_last, .frame_priv, .src_id);

  mcv_validator dut_u (.clk, .reset_n, .byte_valid, .byte_data, .msg_last, .frame_priv, .role, .src_id,
    .ulp_supported, .store_free, .outstanding_clear, .outstanding_src, .quiesce_all_done, .reconfig_done,
    .path_all_normal, .outcome_valid, .outcome, .alert_code, .msg_code, .msg_tag, .msg_path, .msg_src,
    .invalidate_links, .halt_outbound(), .send_quiesce(), .master_response, .requery_nodes, .reissue_cmds,
    .clear_table, .start_reconfig(), .ulp_all_ready, .ulp_node_ready);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // Sampled mid-cycle, where the registered outcome has settled
  always @(negedge clk)
    if (outcome_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        got = 'x;
      else
        got = exp_q.pop_front();
      `CHK({outcome, alert_code, msg_code, msg_tag, msg_path, msg_src}, got)
    end

  task automatic msg(input logic [7:0] code, input int dl, input int n, input logic priv,
    input mcv_pkg::mcv_outcome_t oc, input logic [23:0] al, input logic [15:0] ov);
    logic [255:0] m;
    logic [31:0] pa;
    logic go;
    m = '0;
    pa = '0;
    go = 1'b1;
    for (int i = 1; i < dl && i < n; i++)
      m[8*i +: 8] = rnd();
    m[7:0] = code;
    if (n > 18)
      m[151:128] = {8'h00, ov};
    for (int k = 0; k < 4; k++)
    begin
      if (go)
        pa[31-8*k -: 8] = m[32+8*k +: 8];
      go = go & m[39+8*k];
    end
    exp_q.push_back({oc, al, code, m[23:16], m[31:24], pa, cur_src});
    snd_u.send(m, n, priv, cur_src);
  endtask

  task automatic clr();
    @(posedge clk);
    outstanding_clear <= 1'b1;
    outstanding_src <= cur_src;
    @(posedge clk);
    outstanding_clear <= 1'b0;
  endtask

  task automatic pulses(input int c, inout logic [6:0] s);
    repeat (c)
    begin
      @(posedge clk);
      s = s | {master_response, invalidate_links, clear_table, ulp_all_ready, ulp_node_ready, requery_nodes,
        reissue_cmds};
    end
  endtask

  // Done inputs stay low first, so any early answer to the master shows
  task automatic alert(input logic [15:0] ov, input logic [6:0] e1, input logic [6:0] e2);
    logic [6:0] s;
    s = '0;
    msg(8'h05, 19, 19, 1'b1, mcv_pkg::MCV_OUT_PROCESS, 24'h0, ov);
    pulses(8, s);
    `CHK(s, e1)
    {quiesce_all_done, reconfig_done, path_all_normal} <= 3'h7;
    pulses(4, s);
    `CHK(s, e2)
    {quiesce_all_done, reconfig_done, path_all_normal} <= 3'h0;
    clr();
  endtask

  initial
  begin
    {reset_n, ulp_supported, store_free, outstanding_clear, quiesce_all_done, reconfig_done, path_all_normal} = 7'h0;
    outstanding_src = 8'h00;
    role = mcv_pkg::MCV_ROLE_CFG_MGR;
    cur_src = 8'h00;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    ulp_supported <= 1'b1;
    store_free <= 1'b1;
    cur_src = rnd();
    msg(8'h80 | rnd(), 4, 4, 1'b0, mcv_pkg::MCV_OUT_ULP, 24'h0, 16'h0);
    ulp_supported <= 1'b0;
    msg(8'h80 | rnd(), 4, 4, 1'b1, mcv_pkg::MCV_OUT_ALERT, mcv_pkg::ALERT_UNSUPPORTED_ULP, 16'h0);
    ulp_supported <= 1'b1;
    foreach (bad[i])
      msg(bad[i][7:0], 4, 4, bad[i][8], mcv_pkg::MCV_OUT_ALERT, mcv_pkg::ALERT_UNKNOWN_MSG, 16'h0);
    role <= mcv_pkg::MCV_ROLE_NODE;
    msg(8'h05, 19, 19, 1'b1, mcv_pkg::MCV_OUT_ALERT, mcv_pkg::ALERT_UNKNOWN_MSG, 16'h0005);
    role <= mcv_pkg::MCV_ROLE_MASTER;
    msg(8'h04, 4, 4, 1'b1, mcv_pkg::MCV_OUT_PROCESS, 24'h0, 16'h0);
    role <= mcv_pkg::MCV_ROLE_CFG_MGR;
    msg(8'h04, 4, 4, 1'b1, mcv_pkg::MCV_OUT_ALERT, mcv_pkg::ALERT_UNKNOWN_MSG, 16'h0);
    for (logic [7:0] c = 8'h20; c < 8'h24; c++)
      msg(c, 4, 4, 1'b0, mcv_pkg::MCV_OUT_PROCESS, 24'h0, 16'h0);
    msg(8'h02, 8, 4, 1'b1, mcv_pkg::MCV_OUT_ALERT, mcv_pkg::ALERT_TOO_SHORT, 16'h0);
    msg(8'h02, 8, 8, 1'b1, mcv_pkg::MCV_OUT_PROCESS, 24'h0, 16'h0);
    msg(8'h06, 8, 8, 1'b1, mcv_pkg::MCV_OUT_OVERLAP, 24'h0, 16'h0);
    clr();
    msg(8'h0a, 4, 4, 1'b1, mcv_pkg::MCV_OUT_PROCESS, 24'h0, 16'h0);
    clr();
    store_free <= 1'b0;
    msg(8'h00, 4, 4, 1'b1, mcv_pkg::MCV_OUT_DISCARD, 24'h0, 16'h0);
    store_free <= 1'b1;
    msg(8'h00, 4, 32, 1'b1, mcv_pkg::MCV_OUT_PROCESS, 24'h0, 16'h0);
    alert(16'h0005, 7'h20, 7'h63);
    alert(16'h0306, 7'h10, 7'h50);
    alert(16'h0106, 7'h48, 7'h48);
    alert(16'h0206, 7'h00, 7'h44);
    alert(16'h0406, 7'h00, 7'h44);
    repeat (4) @(posedge clk);
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule
